// ### hdl/igf_cfg.svh
// register offsets, reset values and widths of the image geometry stage
// assumes byte addressing on a 32-bit Avalon-MM slave, one word per register
`ifndef IGF_CFG_SVH
`define IGF_CFG_SVH

// register byte offsets
`define IGF_REG_CTRL       8'h00
`define IGF_REG_SENSOR_W   8'h04
`define IGF_REG_SENSOR_H   8'h08
`define IGF_REG_MAX_COLS   8'h0C
`define IGF_REG_MAX_ROWS   8'h10
`define IGF_REG_ROI_W      8'h14
`define IGF_REG_ROI_H      8'h18
`define IGF_REG_ROI_COL    8'h1C
`define IGF_REG_ROI_ROW    8'h20
`define IGF_REG_PIX_FMT    8'h24
`define IGF_REG_PIX_SIZE   8'h28
`define IGF_REG_CFA        8'h2C
`define IGF_REG_DR_MIN     8'h30
`define IGF_REG_DR_MAX     8'h34
`define IGF_REG_MERGE_SEL  8'h38
`define IGF_REG_MERGE_COLS 8'h3C
`define IGF_REG_MERGE_ROWS 8'h40
`define IGF_REG_DECIM      8'h44
`define IGF_REG_STATUS     8'h48

// field positions
`define IGF_CTRL_REV_X     0
`define IGF_CTRL_REV_Y     1
`define IGF_CTRL_CORE_EN   2
`define IGF_MERGE_AVG_BIT  8
`define IGF_DECIM_ROWS_LSB 8

// sensor dimensions and reset values
`define IGF_SENSOR_COLS    2448
`define IGF_SENSOR_ROWS    2048
`define IGF_DIM_W          12
`define IGF_ACC_W          24
`define IGF_PIX_W          16
`define IGF_DR_MIN_VAL     32'h0000_0000
`define IGF_DR_MAX_16      32'h0000_FFFF
`define IGF_DR_MAX_8       32'h0000_00FF
`define IGF_SIZE_16        32'h0000_0010
`define IGF_SIZE_8         32'h0000_0008
`define IGF_ROI_W_RST      12'h990
`define IGF_ROI_H_RST      12'h800

`endif

// ### hdl/igf_pkg.sv
// types shared by the image geometry stage
// assumes nothing beyond the constants header
package igf_pkg;
	// frame phases, gray coded along idle, fill, drain
	typedef enum logic [1:0] {
		IGF_IDLE  = 2'b00,
		IGF_FILL  = 2'b01,
		IGF_DRAIN = 2'b11
	} igf_state_e;

	// pixel format codes seen on the register bus
	typedef enum logic [2:0] {
		IGF_MONO8                = 3'h0,
		IGF_MONO16               = 3'h1,
		IGF_CFA_RED_GREEN_16     = 3'h4,
		IGF_CFA_GREEN_RED_16     = 3'h5,
		IGF_CFA_GREEN_BLUE_16    = 3'h6,
		IGF_CFA_BLUE_GREEN_16    = 3'h7
	} igf_fmt_e;

	typedef logic [11:0] igf_dim_t;
endpackage

// ### hdl/igf_geometry.sv
// image geometry stage: binning or decimation, mirroring, region cropping
// assumes pixel streams and register bus all run on ref_clk; one frame buffer
`timescale 1ns/1ps
`include "igf_cfg.svh"

// Notes on behaviour
// - horizontal mirror reverses pixel order per line
// - vertical mirror reverses line order
// - cropping applies after the mirror
// - horizontal mirror turns red-green into green-red
// - vertical mirror turns red-green into green-blue
// - max columns follow horizontal binning
// - max rows follow vertical binning
// - max sizes ignore crop settings
// - merge adjacent columns by factor, one means off
// - merge adjacent rows by factor, one means off
// - decimation acts only with binning at one
// - selector picks which binning engine is programmed
// - crop window placed at column and row offsets
// - output size equals programmed crop size clipped to fit the maximum, a size of zero giving one
// - sensor width and height readable
// - pixel size in bits readable
// - filter arrangement only for cfa formats
// - darkest value readable
// - brightest value readable
// - core enable selects optional mono mode
// - binning acts only with decimation at one
module igf_geometry #(
	parameter int SENSOR_COLS = `IGF_SENSOR_COLS,
	parameter int SENSOR_ROWS = `IGF_SENSOR_ROWS
) (
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	// avalon-mm slave
	input  wire logic [7:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic      [31:0]             avs_readdata,
	output logic                         avs_waitrequest,
	// pixel stream from sensor readout
	input  wire logic                    pix_in_valid,
	output logic                         pix_in_ready,
	input  wire logic [`IGF_PIX_W-1:0]   pix_in_data,
	input  wire logic                    pix_in_sof,
	// pixel stream towards transport
	output logic                         pix_out_valid,
	input  wire logic                    pix_out_ready,
	output logic      [`IGF_PIX_W-1:0]   pix_out_data,
	output logic                         pix_out_sof,
	output logic                         pix_out_eol,
	output logic                         pix_out_eof,
	// live format code
	output igf_pkg::igf_fmt_e            pix_fmt_now
);
	import igf_pkg::*;

	localparam int DEPTH = SENSOR_COLS * SENSOR_ROWS;
	localparam int AW    = $clog2(DEPTH);
	localparam igf_dim_t SCOLS = igf_dim_t'(SENSOR_COLS);
	localparam igf_dim_t SROWS = igf_dim_t'(SENSOR_ROWS);

	// window selection: {merge, log2 size}; binning and decimation lock out each other
	function automatic logic [3:0] win_sel(input logic [1:0] b0, input logic [1:0] b1, input logic [1:0] dl);
		logic [2:0] bl;
		bl = {1'b0, b0} + {1'b0, b1};
		if (bl != 3'h0 && dl == 2'h0)
			win_sel = {1'b1, bl};
		else if (dl != 2'h0 && bl == 3'h0)
			win_sel = {2'b00, dl};
		else
			win_sel = 4'h0;
	endfunction

	// right shift that turns a merged sum into an average
	function automatic logic [2:0] avg_sh(input logic [1:0] b0, input logic [1:0] b1, input logic a0, input logic a1);
		avg_sh = (a0 ? {1'b0, b0} : 3'h0) + (a1 ? {1'b0, b1} : 3'h0);
	endfunction

	// fit crop window into the maximum: {offset, size}
	function automatic logic [23:0] roi_fit(input igf_dim_t off, input igf_dim_t sz, input igf_dim_t mx);
		igf_dim_t eo;
		igf_dim_t room;
		igf_dim_t es;
		eo   = (off >= mx) ? mx - 12'h001 : off;
		room = mx - eo;
		es   = (sz == 12'h000) ? 12'h001 : ((sz > room) ? room : sz);
		roi_fit = {eo, es};
	endfunction

	// factor write: 1, 2 or 4 accepted, anything else keeps the old value
	function automatic logic [1:0] fac_log(input logic [2:0] v, input logic [1:0] cur);
		unique case (v)
			3'h1: fac_log = 2'h0;
			3'h2: fac_log = 2'h1;
			3'h4: fac_log = 2'h2;
			default: fac_log = cur;
		endcase
	endfunction

	// software state
	logic        rev_x, rev_y, core_en, merge_sel, fmt_mono8, fmt_cfa;
	igf_dim_t    roi_w, roi_h, roi_col_start, roi_row_start;
	logic [1:0]  bin_lc [2];
	logic [1:0]  bin_lr [2];
	logic        bin_ac [2];
	logic        bin_ar [2];
	logic [1:0]  dec_lc, dec_lr;
	logic        ack;
	logic        next_rev_x, next_rev_y, next_core_en, next_merge_sel, next_fmt_mono8, next_fmt_cfa;
	igf_dim_t    next_roi_w, next_roi_h, next_roi_col_start, next_roi_row_start;
	logic [1:0]  next_bin_lc [2];
	logic [1:0]  next_bin_lr [2];
	logic        next_bin_ac [2];
	logic        next_bin_ar [2];
	logic [1:0]  next_dec_lc, next_dec_lr;
	logic        next_ack;
	logic [31:0] next_readdata, rd_val, wr_val, be_mask;
	logic        wr_go;

	// frame state
	igf_state_e  state, next_state;
	igf_dim_t    f_maxc, f_maxr, f_w, f_h, f_x0, f_y0, cc, rr, ox, oy;
	igf_dim_t    next_f_maxc, next_f_maxr, next_f_w, next_f_h, next_f_x0, next_f_y0;
	igf_dim_t    next_cc, next_rr, next_ox, next_oy;
	logic [2:0]  f_clog, f_rlog, next_f_clog, next_f_rlog;
	logic [3:0]  f_shift, next_f_shift;
	logic        f_cmerge, f_rmerge, f_rev_x, f_rev_y, f_mono8, issued;
	logic        next_f_cmerge, next_f_rmerge, next_f_rev_x, next_f_rev_y, next_f_mono8, next_issued;
	logic [`IGF_ACC_W-1:0] hacc, next_hacc;
	logic        next_out_valid, next_out_sof, next_out_eol, next_out_eof;
	logic [`IGF_PIX_W-1:0] next_out_data;

	// derived live values
	logic [3:0]  wc, wr;
	logic [2:0]  shc, shr;
	igf_dim_t    max_cols, max_rows;
	logic [23:0] fit_c, fit_r;
	logic [1:0]  cfa_code;

	// frame buffer, one merged cell per entry
	logic [`IGF_ACC_W-1:0] fbuf [0:DEPTH-1];
	logic                  mem_we, take_in, load;
	logic [AW-1:0]         mem_wa, mem_ra;
	logic [`IGF_ACC_W-1:0] mem_wd, mem_rd, word;

	// live geometry seen by software and latched at frame start
	always_comb
	begin
		wc  = win_sel(bin_lc[0], bin_lc[1], dec_lc);
		wr  = win_sel(bin_lr[0], bin_lr[1], dec_lr);
		shc = wc[3] ? avg_sh(bin_lc[0], bin_lc[1], bin_ac[0], bin_ac[1]) : 3'h0;
		shr = wr[3] ? avg_sh(bin_lr[0], bin_lr[1], bin_ar[0], bin_ar[1]) : 3'h0;
		max_cols = SCOLS >> wc[2:0];
		max_rows = SROWS >> wr[2:0];
		fit_c = roi_fit(roi_col_start, roi_w, max_cols);
		fit_r = roi_fit(roi_row_start, roi_h, max_rows);
		cfa_code = {rev_y, rev_x};
		if (!fmt_cfa)
			pix_fmt_now = core_en && fmt_mono8 ? IGF_MONO8 : IGF_MONO16;
		else
			pix_fmt_now = igf_fmt_e'({1'b1, cfa_code});
	end

	// register readback
	always_comb
	begin
		unique case (avs_address)
			`IGF_REG_CTRL:       rd_val = {29'h0, core_en, rev_y, rev_x};
			`IGF_REG_SENSOR_W:   rd_val = {20'h0, SCOLS};
			`IGF_REG_SENSOR_H:   rd_val = {20'h0, SROWS};
			`IGF_REG_MAX_COLS:   rd_val = {20'h0, max_cols};
			`IGF_REG_MAX_ROWS:   rd_val = {20'h0, max_rows};
			`IGF_REG_ROI_W:      rd_val = {20'h0, roi_w};
			`IGF_REG_ROI_H:      rd_val = {20'h0, roi_h};
			`IGF_REG_ROI_COL:    rd_val = {20'h0, roi_col_start};
			`IGF_REG_ROI_ROW:    rd_val = {20'h0, roi_row_start};
			`IGF_REG_PIX_FMT:    rd_val = {29'h0, pix_fmt_now};
			`IGF_REG_PIX_SIZE:   rd_val = (pix_fmt_now == IGF_MONO8) ? `IGF_SIZE_8 : `IGF_SIZE_16;
			`IGF_REG_CFA:        rd_val = fmt_cfa ? {29'h0, 1'b1, cfa_code} : 32'h0;
			`IGF_REG_DR_MIN:     rd_val = `IGF_DR_MIN_VAL;
			`IGF_REG_DR_MAX:     rd_val = (pix_fmt_now == IGF_MONO8) ? `IGF_DR_MAX_8 : `IGF_DR_MAX_16;
			`IGF_REG_MERGE_SEL:  rd_val = {31'h0, merge_sel};
			`IGF_REG_MERGE_COLS: rd_val = {23'h0, bin_ac[merge_sel], 5'h0, 3'(3'h1 << bin_lc[merge_sel])};
			`IGF_REG_MERGE_ROWS: rd_val = {23'h0, bin_ar[merge_sel], 5'h0, 3'(3'h1 << bin_lr[merge_sel])};
			`IGF_REG_DECIM:      rd_val = {21'h0, 3'(3'h1 << dec_lr), 5'h0, 3'(3'h1 << dec_lc)};
			`IGF_REG_STATUS:     rd_val = {30'h0, state == IGF_DRAIN, state == IGF_FILL};
			default:             rd_val = 32'h0;
		endcase
	end

	// bus handshake and register writes; one wait cycle per access
	always_comb
	begin
		be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wr_val  = (rd_val & ~be_mask) | (avs_writedata & be_mask);
		wr_go   = avs_write && ack;
		avs_waitrequest = (avs_read || avs_write) && !ack;
		next_ack = (avs_read || avs_write) && !ack;
		next_readdata = (avs_read && !ack) ? rd_val : avs_readdata;
		next_rev_x = rev_x;
		next_rev_y = rev_y;
		next_core_en = core_en;
		next_merge_sel = merge_sel;
		next_fmt_mono8 = fmt_mono8;
		next_fmt_cfa = fmt_cfa;
		next_roi_w = roi_w;
		next_roi_h = roi_h;
		next_roi_col_start = roi_col_start;
		next_roi_row_start = roi_row_start;
		next_bin_lc = bin_lc;
		next_bin_lr = bin_lr;
		next_bin_ac = bin_ac;
		next_bin_ar = bin_ar;
		next_dec_lc = dec_lc;
		next_dec_lr = dec_lr;
		if (wr_go)
		begin
			unique case (avs_address)
				`IGF_REG_CTRL:
				begin
					next_rev_x = wr_val[`IGF_CTRL_REV_X];
					next_rev_y = wr_val[`IGF_CTRL_REV_Y];
					next_core_en = wr_val[`IGF_CTRL_CORE_EN];
				end
				`IGF_REG_ROI_W:      next_roi_w = wr_val[11:0];
				`IGF_REG_ROI_H:      next_roi_h = wr_val[11:0];
				`IGF_REG_ROI_COL:    next_roi_col_start = wr_val[11:0];
				`IGF_REG_ROI_ROW:    next_roi_row_start = wr_val[11:0];
				`IGF_REG_PIX_FMT:
				begin
					next_fmt_cfa = wr_val[2];
					next_fmt_mono8 = (wr_val[2:0] == IGF_MONO8);
				end
				`IGF_REG_MERGE_SEL:  next_merge_sel = wr_val[0];
				`IGF_REG_MERGE_COLS:
				begin
					next_bin_lc[merge_sel] = fac_log(wr_val[2:0], bin_lc[merge_sel]);
					next_bin_ac[merge_sel] = wr_val[`IGF_MERGE_AVG_BIT];
				end
				`IGF_REG_MERGE_ROWS:
				begin
					next_bin_lr[merge_sel] = fac_log(wr_val[2:0], bin_lr[merge_sel]);
					next_bin_ar[merge_sel] = wr_val[`IGF_MERGE_AVG_BIT];
				end
				`IGF_REG_DECIM:
				begin
					next_dec_lc = fac_log(wr_val[2:0], dec_lc);
					next_dec_lr = fac_log(wr_val[`IGF_DECIM_ROWS_LSB+2:`IGF_DECIM_ROWS_LSB], dec_lr);
				end
				default: next_ack = 1'b0;
			endcase
		end
	end

	// software state registers
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ack <= 1'b0;
			avs_readdata <= 32'h0;
			rev_x <= 1'b0;
			rev_y <= 1'b0;
			core_en <= 1'b0;
			merge_sel <= 1'b0;
			fmt_mono8 <= 1'b0;
			fmt_cfa <= 1'b1;
			roi_w <= `IGF_ROI_W_RST;
			roi_h <= `IGF_ROI_H_RST;
			roi_col_start <= 12'h000;
			roi_row_start <= 12'h000;
			bin_lc <= '{2'h0, 2'h0};
			bin_lr <= '{2'h0, 2'h0};
			bin_ac <= '{1'b0, 1'b0};
			bin_ar <= '{1'b0, 1'b0};
			dec_lc <= 2'h0;
			dec_lr <= 2'h0;
		end
		else
		begin
			ack <= next_ack;
			avs_readdata <= next_readdata;
			rev_x <= next_rev_x;
			rev_y <= next_rev_y;
			core_en <= next_core_en;
			merge_sel <= next_merge_sel;
			fmt_mono8 <= next_fmt_mono8;
			fmt_cfa <= next_fmt_cfa;
			roi_w <= next_roi_w;
			roi_h <= next_roi_h;
			roi_col_start <= next_roi_col_start;
			roi_row_start <= next_roi_row_start;
			bin_lc <= next_bin_lc;
			bin_lr <= next_bin_lr;
			bin_ac <= next_bin_ac;
			bin_ar <= next_bin_ar;
			dec_lc <= next_dec_lc;
			dec_lr <= next_dec_lr;
		end
	end

	// frame sequencing: capture a sensor frame, then send the cropped window
	always_comb
	begin
		logic [11:0] cmask, rmask;
		igf_dim_t    bc, br, sx, sy;
		cmask = 12'((13'h1 << f_clog) - 13'h1);
		rmask = 12'((13'h1 << f_rlog) - 13'h1);
		bc = cc >> f_clog;
		br = rr >> f_rlog;
		next_state = state;
		next_cc = cc;
		next_rr = rr;
		next_ox = ox;
		next_oy = oy;
		next_hacc = hacc;
		next_issued = issued;
		next_f_maxc = f_maxc;
		next_f_maxr = f_maxr;
		next_f_w = f_w;
		next_f_h = f_h;
		next_f_x0 = f_x0;
		next_f_y0 = f_y0;
		next_f_clog = f_clog;
		next_f_rlog = f_rlog;
		next_f_shift = f_shift;
		next_f_cmerge = f_cmerge;
		next_f_rmerge = f_rmerge;
		next_f_rev_x = f_rev_x;
		next_f_rev_y = f_rev_y;
		next_f_mono8 = f_mono8;
		pix_in_ready = (state != IGF_DRAIN);
		take_in = pix_in_valid && (state == IGF_FILL || pix_in_sof);
		word = (f_cmerge && (cc & cmask) != 12'h000) ? hacc + `IGF_ACC_W'(pix_in_data) : `IGF_ACC_W'(pix_in_data);
		if ((cc & cmask) != 12'h000 && !f_cmerge)
			word = hacc;
		mem_wa = AW'(br) * AW'(f_maxc) + AW'(bc);
		mem_we = 1'b0;
		mem_wd = word;
		if (take_in && (cc & cmask) == cmask && bc < f_maxc && br < f_maxr)
		begin
			if ((rr & rmask) == 12'h000)
				mem_we = 1'b1;
			else if (f_rmerge)
			begin
				mem_we = 1'b1;
				mem_wd = fbuf[mem_wa] + word;
			end
		end
		sx = f_x0 + ox;
		sy = f_y0 + oy;
		if (f_rev_x)
			sx = f_maxc - 12'h001 - sx;
		if (f_rev_y)
			sy = f_maxr - 12'h001 - sy;
		mem_ra = AW'(sy) * AW'(f_maxc) + AW'(sx);
		mem_rd = fbuf[mem_ra] >> (f_shift);
		load = (state == IGF_DRAIN) && !issued && (!pix_out_valid || pix_out_ready);
		next_out_valid = load || (pix_out_valid && !pix_out_ready);
		next_out_data = pix_out_data;
		next_out_sof = pix_out_sof;
		next_out_eol = pix_out_eol;
		next_out_eof = pix_out_eof;
		if (load)
		begin
			next_out_data = (mem_rd[`IGF_ACC_W-1:`IGF_PIX_W] != 8'h00) ? 16'hFFFF : mem_rd[`IGF_PIX_W-1:0];
			if (f_mono8)
				next_out_data = {8'h00, next_out_data[15:8]};
			next_out_sof = (ox == 12'h000) && (oy == 12'h000);
			next_out_eol = (ox == f_w - 12'h001);
			next_out_eof = (ox == f_w - 12'h001) && (oy == f_h - 12'h001);
			if (ox == f_w - 12'h001)
			begin
				next_ox = 12'h000;
				next_oy = oy + 12'h001;
				next_issued = (oy == f_h - 12'h001);
			end
			else
				next_ox = ox + 12'h001;
		end
		unique case (state)
			IGF_IDLE:
			begin
				if (take_in)
				begin
					next_state = IGF_FILL;
					next_f_maxc = max_cols;
					next_f_maxr = max_rows;
					next_f_x0 = fit_c[23:12];
					next_f_w = fit_c[11:0];
					next_f_y0 = fit_r[23:12];
					next_f_h = fit_r[11:0];
					next_f_clog = wc[2:0];
					next_f_rlog = wr[2:0];
					next_f_cmerge = wc[3];
					next_f_rmerge = wr[3];
					next_f_shift = {1'b0, shc} + {1'b0, shr};
					next_f_rev_x = rev_x;
					next_f_rev_y = rev_y;
					next_f_mono8 = core_en && fmt_mono8 && !fmt_cfa;
					// the start pixel itself is stored using live settings
					mem_wa = '0;
					mem_we = (wc[2:0] == 3'h0);
					mem_wd = `IGF_ACC_W'(pix_in_data);
					next_hacc = `IGF_ACC_W'(pix_in_data);
					next_cc = 12'h001;
					next_rr = 12'h000;
				end
			end
			IGF_FILL:
			begin
				if (take_in)
				begin
					next_hacc = word;
					if (cc == SCOLS - 12'h001)
					begin
						next_cc = 12'h000;
						next_rr = rr + 12'h001;
						if (rr == SROWS - 12'h001)
						begin
							next_state = IGF_DRAIN;
							next_ox = 12'h000;
							next_oy = 12'h000;
							next_issued = 1'b0;
						end
					end
					else
						next_cc = cc + 12'h001;
				end
			end
			IGF_DRAIN:
			begin
				if (issued && (!pix_out_valid || pix_out_ready))
					next_state = IGF_IDLE;
			end
		endcase
	end

	// frame buffer storage
	always_ff @(posedge ref_clk)
	begin
		if (mem_we)
			fbuf[mem_wa] <= mem_wd;
	end

	// frame state registers
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= IGF_IDLE;
			cc <= 12'h000;
			rr <= 12'h000;
			ox <= 12'h000;
			oy <= 12'h000;
			hacc <= '0;
			issued <= 1'b0;
			f_maxc <= SCOLS;
			f_maxr <= SROWS;
			f_w <= `IGF_ROI_W_RST;
			f_h <= `IGF_ROI_H_RST;
			f_x0 <= 12'h000;
			f_y0 <= 12'h000;
			f_clog <= 3'h0;
			f_rlog <= 3'h0;
			f_shift <= 4'h0;
			f_cmerge <= 1'b0;
			f_rmerge <= 1'b0;
			f_rev_x <= 1'b0;
			f_rev_y <= 1'b0;
			f_mono8 <= 1'b0;
			pix_out_valid <= 1'b0;
			pix_out_data <= 16'h0000;
			pix_out_sof <= 1'b0;
			pix_out_eol <= 1'b0;
			pix_out_eof <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cc <= next_cc;
			rr <= next_rr;
			ox <= next_ox;
			oy <= next_oy;
			hacc <= next_hacc;
			issued <= next_issued;
			f_maxc <= next_f_maxc;
			f_maxr <= next_f_maxr;
			f_w <= next_f_w;
			f_h <= next_f_h;
			f_x0 <= next_f_x0;
			f_y0 <= next_f_y0;
			f_clog <= next_f_clog;
			f_rlog <= next_f_rlog;
			f_shift <= next_f_shift;
			f_cmerge <= next_f_cmerge;
			f_rmerge <= next_f_rmerge;
			f_rev_x <= next_f_rev_x;
			f_rev_y <= next_f_rev_y;
			f_mono8 <= next_f_mono8;
			pix_out_valid <= next_out_valid;
			pix_out_data <= next_out_data;
			pix_out_sof <= next_out_sof;
			pix_out_eol <= next_out_eol;
			pix_out_eof <= next_out_eof;
		end
	end
endmodule

// ### test/igf_geometry_assertions.sv
// port checker for the image geometry stage
// sees only top ports; bound to every igf_geometry instance below
`timescale 1ns/1ps
module igf_geometry_assertions #(
	parameter int SENSOR_COLS = 8
) (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// register bus
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// pixel streams
	input wire logic        pix_in_ready,
	input wire logic        pix_out_valid,
	input wire logic        pix_out_ready,
	input wire logic [15:0] pix_out_data,
	input wire logic        pix_out_sof,
	input wire logic        pix_out_eol,
	input wire logic        pix_out_eof
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// a read finishing in this cycle
	wire logic rd_done = avs_read && !avs_waitrequest;

	property p_wait_first; $rose(avs_read) |-> avs_waitrequest; endproperty
	a_wait_first: assert property (p_wait_first) else $error("read answered without wait");
	property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait state too long");
	property p_sensor_w; rd_done && avs_address == 8'h04 |-> avs_readdata == SENSOR_COLS; endproperty
	a_sensor_w: assert property (p_sensor_w) else $error("sensor width wrong");
	property p_dark; rd_done && avs_address == 8'h30 |-> avs_readdata == 32'h0; endproperty
	a_dark: assert property (p_dark) else $error("darkest value wrong");
	property p_unmapped; rd_done && avs_address > 8'h48 |-> avs_readdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_hold;
		pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out_data)
			&& $stable({pix_out_sof, pix_out_eol, pix_out_eof});
	endproperty
	a_hold: assert property (p_hold) else $error("stalled beat changed");
	property p_eof_eol; pix_out_valid && pix_out_eof |-> pix_out_eol; endproperty
	a_eof_eol: assert property (p_eof_eol) else $error("frame end not at line end");
	property p_first_sof; $rose(pix_out_valid) |-> pix_out_sof; endproperty
	a_first_sof: assert property (p_first_sof) else $error("frame opens without start flag");
	property p_drain_stall; pix_out_valid |-> !pix_in_ready; endproperty
	a_drain_stall: assert property (p_drain_stall) else $error("input taken while draining");
	property p_end_idle; pix_out_valid && pix_out_ready && pix_out_eof |=> !pix_out_valid && pix_in_ready; endproperty
	a_end_idle: assert property (p_end_idle) else $error("no idle after frame end");
endmodule

bind igf_geometry igf_geometry_assertions #(.SENSOR_COLS(SENSOR_COLS)) u_igf_geometry_assertions (
	.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.pix_in_ready(pix_in_ready), .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
	.pix_out_data(pix_out_data), .pix_out_sof(pix_out_sof), .pix_out_eol(pix_out_eol),
	.pix_out_eof(pix_out_eof));

// ### test/igf_host_sink.sv
// host-side model taking output pixels, with an optional stall pattern
// assumes beats pass on ref_clk edges with valid and ready high
`timescale 1ns/1ps
module igf_host_sink (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// stall select
	input wire logic        slow,
	// pixel stream
	input wire logic        pix_out_valid,
	output logic            pix_out_ready,
	input wire logic [15:0] pix_out_data,
	input wire logic        pix_out_sof,
	input wire logic        pix_out_eol,
	input wire logic        pix_out_eof
);
	logic [18:0] beats[$];
	logic [1:0]  tick;
	// ready one cycle in four when stalling
	assign pix_out_ready = !slow || tick == 2'h3;
	// stall counter and capture of accepted beats
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
			tick <= 2'h0;
		else
		begin
			tick <= tick + 2'h1;
			if (pix_out_valid && pix_out_ready)
				beats.push_back({pix_out_eof, pix_out_eol, pix_out_sof, pix_out_data});
		end
endmodule

// ### test/igf_geometry_test.sv
// self-checking bench: register tasks on the avalon bus, frames through the stage
// assumes a small sensor set by parameter and the host model as sink
`timescale 1ns/1ps
`include "igf_cfg.svh"
module igf_geometry_test;
	import igf_pkg::*;
	localparam int COLS = 8;
	localparam int ROWS = 4;
	logic        ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, slow;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic        pix_in_valid, pix_in_ready, pix_in_sof, pix_out_valid, pix_out_ready;
	logic        pix_out_sof, pix_out_eol, pix_out_eof;
	logic [15:0] pix_in_data, pix_out_data;
	igf_fmt_e    pix_fmt_now;
	int          n_fail, checks_done, cyc, k;

	igf_geometry #(.SENSOR_COLS(COLS), .SENSOR_ROWS(ROWS)) u_igf_geometry (
		.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pix_in_valid(pix_in_valid),
		.pix_in_ready(pix_in_ready), .pix_in_data(pix_in_data), .pix_in_sof(pix_in_sof),
		.pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data),
		.pix_out_sof(pix_out_sof), .pix_out_eol(pix_out_eol), .pix_out_eof(pix_out_eof),
		.pix_fmt_now(pix_fmt_now));
	igf_host_sink u_igf_host_sink (
		.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow), .pix_out_valid(pix_out_valid),
		.pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data), .pix_out_sof(pix_out_sof),
		.pix_out_eol(pix_out_eol), .pix_out_eof(pix_out_eof));

	// free-running clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_fail++;
			$display("mismatch at %0t: timeout", $time);
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_write <= 1'b1;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge ref_clk iff !avs_waitrequest);
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		avs_read <= 1'b1;
		avs_address <= a;
		@(posedge ref_clk iff !avs_waitrequest);
		avs_read <= 1'b0;
		chk(avs_readdata, exp);
	endtask

	// one sensor frame in, cropped and mirrored window checked beat by beat
	task automatic frame(input logic [1:0] ctl, input int w, input int h, input int x, input int y, input int vb);
		int r, c, er, ec, n, base;
		wr(`IGF_REG_CTRL, {30'h0, ctl});
		wr(`IGF_REG_MERGE_ROWS, 32'(vb));
		wr(`IGF_REG_ROI_W, 32'(w));
		wr(`IGF_REG_ROI_H, 32'(h));
		wr(`IGF_REG_ROI_COL, 32'(x));
		wr(`IGF_REG_ROI_ROW, 32'(y));
		base = u_igf_host_sink.beats.size();
		@(posedge ref_clk);
		for (r = 0; r < ROWS; r++)
			for (c = 0; c < COLS; c++)
			begin
				pix_in_valid <= 1'b1;
				pix_in_sof <= (r == 0 && c == 0);
				pix_in_data <= {8'(r), 8'(c)};
				@(posedge ref_clk iff pix_in_ready);
			end
		pix_in_valid <= 1'b0;
		while (u_igf_host_sink.beats.size() - base < w * h)
			@(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
		chk(32'(u_igf_host_sink.beats.size() - base), 32'(w * h));
		for (n = 0; n < w * h && n < u_igf_host_sink.beats.size() - base; n++)
		begin
			er = ctl[1] ? ROWS / vb - 1 - (y + n / w) : y + n / w;
			ec = ctl[0] ? COLS - 1 - (x + n % w) : x + n % w;
			ec = vb * (vb * er * 256 + ec) + (vb - 1) * 256; // vb summed rows of {row, col}
			chk(u_igf_host_sink.beats[base + n], {n == w * h - 1, n % w == w - 1, n == 0, 16'(ec)});
		end
		$display("test frame ctl %0d done", ctl);
	endtask

	// main sequence
	initial
	begin
		{reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{pix_in_valid, pix_in_sof, pix_in_data, slow} = '0;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(`IGF_REG_SENSOR_W, COLS);
		rd(`IGF_REG_SENSOR_H, ROWS);
		wr(`IGF_REG_SENSOR_W, 32'h5);
		rd(`IGF_REG_SENSOR_W, COLS);
		rd(`IGF_REG_DR_MIN, 32'h0);
		rd(`IGF_REG_DR_MAX, 32'hFFFF);
		rd(`IGF_REG_PIX_SIZE, 32'h10);
		rd(8'h80, 32'h0);
		$display("test read-only done");
		for (k = 0; k < 4; k++)
		begin
			wr(`IGF_REG_CTRL, 32'(k));
			rd(`IGF_REG_PIX_FMT, 32'(4 + k));
			rd(`IGF_REG_CFA, 32'(4 + k));
			chk(32'(pix_fmt_now), 32'(4 + k));
		end
		wr(`IGF_REG_CTRL, 32'h0);
		wr(`IGF_REG_PIX_FMT, 32'h0);
		rd(`IGF_REG_PIX_FMT, 32'h1);
		rd(`IGF_REG_CFA, 32'h0);
		wr(`IGF_REG_CTRL, 32'h4);
		rd(`IGF_REG_PIX_FMT, 32'h0);
		rd(`IGF_REG_PIX_SIZE, 32'h8);
		rd(`IGF_REG_DR_MAX, 32'hFF);
		$display("test formats done");
		wr(`IGF_REG_ROI_COL, 32'h3);
		wr(`IGF_REG_MERGE_COLS, 32'h2);
		rd(`IGF_REG_MAX_COLS, COLS / 2);
		wr(`IGF_REG_MERGE_ROWS, 32'h2);
		rd(`IGF_REG_MAX_ROWS, ROWS / 2);
		wr(`IGF_REG_MERGE_ROWS, 32'h104);
		rd(`IGF_REG_MERGE_ROWS, 32'h104);
		rd(`IGF_REG_MAX_ROWS, ROWS / 4);
		wr(`IGF_REG_MERGE_COLS, 32'h3);
		rd(`IGF_REG_MAX_COLS, COLS / 2);
		wr(`IGF_REG_MERGE_SEL, 32'h1);
		wr(`IGF_REG_MERGE_COLS, 32'h2);
		rd(`IGF_REG_MAX_COLS, COLS / 4);
		wr(`IGF_REG_DECIM, 32'h2);
		rd(`IGF_REG_MAX_COLS, COLS);
		wr(`IGF_REG_DECIM, 32'h101);
		wr(`IGF_REG_MERGE_COLS, 32'h1);
		wr(`IGF_REG_MERGE_SEL, 32'h0);
		wr(`IGF_REG_MERGE_COLS, 32'h1);
		wr(`IGF_REG_MERGE_ROWS, 32'h1);
		rd(`IGF_REG_MAX_COLS, COLS);
		rd(`IGF_REG_MAX_ROWS, ROWS);
		$display("test binning done");
		slow <= 1'b1;
		frame(2'h3, 3, 2, 2, 1, 1);
		frame(2'h2, 8, 1, 0, 3, 1);
		slow <= 1'b0;
		frame(2'h1, 2, 2, 0, 2, 1);
		frame(2'h2, 4, 2, 0, 0, 2);
		summarize();
	end
endmodule
